//--- mli_exec_top.sv
// executor for the move and load instruction group
// What this block does
// RL1: pointer load puts 12-bit literal in pointer; high then low, two cycles.
// RL2: file copy sends value to accumulator on d=0, back to file on d=1.
// RL3: file operand addresses any byte of a 256-byte bank.
// RL4: access bit 0 resolves the file operand in the fixed access bank.
// RL5: access bit 1 takes upper address bits from bank selector.
// RL6: access 0 with extended set: operand up to 95 is indexed offset.
// RL7: reg-to-reg copy reads source, then writes destination; no dummy read.
// RL8: reg-to-reg copy source and destination each reach the whole 4096 bytes.
// RL9: copy first word starts 1100, second word starts 1111.
// RL10: software never targets program counter low or stack top bytes.
// RL11: reg-to-reg copy may read or write the accumulator like memory.
// RL12: bank literal load writes low nibble only; high nibble stays zero.
// RL13: accumulator literal load takes one cycle, flags untouched.
// RL14: accumulator literal load decoded by upper byte 0000 1110.
// RL15: accumulator store writes file register in one cycle, no flags.
// RL16: file copy updates negative and zero flags from moved value.
`timescale 1ns/10ps
module mli_exec_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic [15:0]          instr_i,
  input  wire logic                 instr_valid_i,
  input  wire logic                 ext_set_en_i,
  input  wire logic [7:0]           mem_rd_data_i,
  output mli_pkg::mli_mem_rd_t      mem_rd_o,
  output mli_pkg::mli_mem_wr_t      mem_wr_o,
  output logic [7:0]                acc_o,
  output logic [7:0]                bank_selector_reg_o,
  output logic [2:0][11:0]          indirect_pointer_o,
  output mli_pkg::mli_status_t      status_o,
  output logic [1:0]                q_phase_o,
  output logic                      instr_other_o,
  output logic                      instr_bad_o
);

  logic [1:0]           q_r;
  logic [15:0]          ir_r;
  logic                 ir_vld_r;
  mli_pkg::mli_seq_t    seq_r;
  logic [1:0]           ptr_sel_r;
  logic [7:0]           w_r;
  logic [7:0]           bsr_r;
  logic [11:0]          ptr_r [3];
  logic [7:0]           rd_data_r;
  mli_pkg::mli_mem_rd_t mem_rd_r;
  mli_pkg::mli_mem_wr_t mem_wr_r;
  mli_pkg::mli_status_t status_r;
  logic                 other_r;
  logic                 bad_r;

  logic        is_fcopy;
  logic        is_store;
  logic        is_acc_lit;
  logic        is_bank_lit;
  logic        is_rcopy;
  logic        is_ptr_lit;
  logic        exec_first;
  logic        second_ok;
  logic [11:0] faddr;
  logic        f_indexed;
  logic        wr_req;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;

  // phase divider: one instruction cycle is four clocks
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= mli_pkg::Q_DECODE;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end

  // instruction word latched in the decode phase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ir_r     <= 16'h0000;
      ir_vld_r <= 1'b0;
    end else if (q_r == mli_pkg::Q_DECODE) begin
      ir_r     <= instr_i;
      ir_vld_r <= instr_valid_i;
    end
  end

  // decode of the first word, and of the copy second word
  // RL14: upper byte pattern
  assign is_acc_lit  = ir_r[15:8] == mli_pkg::OP_ACC_LIT;
  assign is_fcopy    = ir_r[15:10] == mli_pkg::OP_FILE_COPY;
  assign is_store    = ir_r[15:9] == mli_pkg::OP_ACC_STORE;
  assign is_bank_lit = ir_r[15:8] == mli_pkg::OP_BANK_LIT;
  // RL9: copy opcode nibbles
  assign is_rcopy    = ir_r[15:12] == mli_pkg::OP_COPY_SRC;
  assign is_ptr_lit  = ir_r[15:6] == mli_pkg::OP_PTR_LIT;
  assign second_ok   = ir_vld_r && (ir_r[15:12] == mli_pkg::OP_SECOND);
  assign exec_first  = ir_vld_r && (seq_r == mli_pkg::SEQ_FIRST);

  // file operand resolution, indexed base is the third pointer
  mli_addr_res u_addr_res (
    .file_i       (ir_r[7:0]),
    .access_sel_i (ir_r[8]),
    .bank_i       (bsr_r[3:0]),
    .ext_en_i     (ext_set_en_i),
    .index_base_i (ptr_r[2]),
    .addr_o       (faddr),
    .indexed_o    (f_indexed)
  );

  // read request issued in the read phase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rd_r <= '0;
    end else if (q_r == mli_pkg::Q_READ && exec_first &&
                 (is_fcopy || is_rcopy)) begin
      mem_rd_r.en <= 1'b1;
      // RL8: full 12-bit source
      mem_rd_r.addr <= is_rcopy ? ir_r[11:0] : faddr;
    end else begin
      mem_rd_r.en <= 1'b0;
    end
  end

  // read data captured in the process phase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_r <= mli_pkg::DATA_RST;
    end else if (q_r == mli_pkg::Q_PROCESS && mem_rd_r.en) begin
      // RL11: accumulator as source
      rd_data_r <= (mem_rd_r.addr == mli_pkg::ACC_ADDR) ? w_r
                                                        : mem_rd_data_i;
    end
  end

  // write target for the write phase
  always_comb begin
    wr_req  = 1'b0;
    wr_addr = faddr;
    wr_data = w_r;
    if (exec_first && is_store) begin
      // RL15: accumulator to file
      wr_req = 1'b1;
    end else if (exec_first && is_fcopy && ir_r[9]) begin
      // RL2: d=1 back to file
      wr_req  = 1'b1;
      wr_data = rd_data_r;
    end else if (seq_r == mli_pkg::SEQ_COPY2 && second_ok) begin
      // RL7: destination written second
      wr_req  = 1'b1;
      wr_addr = ir_r[11:0];
      wr_data = rd_data_r;
    end
  end

  // memory write pulse, the accumulator location stays internal
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_wr_r <= '0;
    end else if (q_r == mli_pkg::Q_WRITE && wr_req &&
                 wr_addr != mli_pkg::ACC_ADDR) begin
      mem_wr_r.en   <= 1'b1;
      mem_wr_r.addr <= wr_addr;
      mem_wr_r.data <= wr_data;
    end else begin
      mem_wr_r.en <= 1'b0;
    end
  end

  // accumulator
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      w_r <= mli_pkg::ACC_RST;
    end else if (q_r == mli_pkg::Q_WRITE) begin
      if (wr_req && wr_addr == mli_pkg::ACC_ADDR) begin
        // RL11: accumulator as target
        w_r <= wr_data;
      end else if (exec_first && is_acc_lit) begin
        // RL13: literal in one cycle
        w_r <= ir_r[7:0];
      end else if (exec_first && is_fcopy && !ir_r[9]) begin
        // RL2: d=0 to accumulator
        w_r <= rd_data_r;
      end
    end
  end

  // bank selector, only the low nibble is loadable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bsr_r <= mli_pkg::BANK_RST;
    end else if (q_r == mli_pkg::Q_WRITE && exec_first && is_bank_lit) begin
      // RL12: low nibble only
      bsr_r <= {4'h0, ir_r[3:0]};
    end
  end

  // status flags, touched only by the file copy
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else if (q_r == mli_pkg::Q_WRITE && exec_first && is_fcopy) begin
      // RL16: flags from moved value
      status_r.neg  <= rd_data_r[7];
      status_r.zero <= rd_data_r == 8'h00;
    end
  end

  // two-word sequencer, steps in the write phase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seq_r     <= mli_pkg::SEQ_FIRST;
      ptr_sel_r <= 2'h0;
    end else if (q_r == mli_pkg::Q_WRITE) begin
      unique case (seq_r)
        mli_pkg::SEQ_FIRST: begin
          if (exec_first && is_rcopy) begin
            seq_r <= mli_pkg::SEQ_COPY2;
          end else if (exec_first && is_ptr_lit &&
                       ir_r[5:4] != mli_pkg::PTR_INVALID) begin
            // RL1: two-cycle pointer load
            seq_r     <= mli_pkg::SEQ_PTR2;
            ptr_sel_r <= ir_r[5:4];
          end
        end
        mli_pkg::SEQ_PTR2:  seq_r <= mli_pkg::SEQ_FIRST;
        mli_pkg::SEQ_COPY2: seq_r <= mli_pkg::SEQ_FIRST;
        default:            seq_r <= mli_pkg::SEQ_FIRST;
      endcase
    end
  end

  // indirect pointers, high nibble first then low byte
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          ptr_r[gi] <= mli_pkg::PTR_RST;
        end else if (q_r == mli_pkg::Q_WRITE) begin
          // RL1: high part first
          if (exec_first && is_ptr_lit && ir_r[5:4] == 2'(gi)) begin
            ptr_r[gi][11:8] <= ir_r[3:0];
          end else if (seq_r == mli_pkg::SEQ_PTR2 && ptr_sel_r == 2'(gi) &&
                       ir_vld_r && ir_r[15:8] == mli_pkg::OP_PTR_SECOND) begin
            ptr_r[gi][7:0] <= ir_r[7:0];
          end
        end
      end
      assign indirect_pointer_o[gi] = ptr_r[gi];
    end
  endgenerate

  // one-phase pulses: word outside this group, invalid pointer select, or broken second word
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      other_r <= 1'b0;
      bad_r   <= 1'b0;
    end else if (q_r == mli_pkg::Q_WRITE) begin
      other_r <= exec_first && !(is_fcopy || is_store || is_acc_lit ||
                 is_bank_lit || is_rcopy || is_ptr_lit);
      bad_r <= (exec_first && is_ptr_lit &&
                ir_r[5:4] == mli_pkg::PTR_INVALID) ||
               (seq_r == mli_pkg::SEQ_COPY2 && !second_ok) ||
               (seq_r == mli_pkg::SEQ_PTR2 && !(ir_vld_r &&
                ir_r[15:8] == mli_pkg::OP_PTR_SECOND));
    end else begin
      other_r <= 1'b0;
      bad_r   <= 1'b0;
    end
  end

  // outputs straight from flops
  assign mem_rd_o            = mem_rd_r;
  assign mem_wr_o            = mem_wr_r;
  assign acc_o               = w_r;
  assign bank_selector_reg_o = bsr_r;
  assign status_o            = status_r;
  assign q_phase_o           = q_r;
  assign instr_other_o       = other_r;
  assign instr_bad_o         = bad_r;

  // checks on the executed behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_lit_value: assert property ( // RL13
    q_r == mli_pkg::Q_WRITE && exec_first && is_acc_lit
    |=> w_r == $past(ir_r[7:0]) && $stable(status_r))
    else $error("literal not loaded into accumulator");
  a_lit_decode: assert property ( // RL14
    q_r == mli_pkg::Q_WRITE && exec_first && ir_r[15:8] == 8'h0E
    |=> w_r == $past(ir_r[7:0]))
    else $error("literal pattern not decoded");
  a_bank_nibble: assert property ( // RL12
    q_r == mli_pkg::Q_WRITE && exec_first && is_bank_lit
    |=> bsr_r == {4'h0, $past(ir_r[3:0])})
    else $error("bank selector load wrong");
  a_store_write: assert property ( // RL15
    q_r == mli_pkg::Q_WRITE && exec_first && is_store &&
    faddr != mli_pkg::ACC_ADDR
    |=> mem_wr_r.en && mem_wr_r.data == $past(w_r) &&
        mem_wr_r.addr == $past(faddr) && $stable(status_r))
    else $error("accumulator store missing");
  a_fcopy_dest: assert property ( // RL2
    q_r == mli_pkg::Q_WRITE && exec_first && is_fcopy && !ir_r[9]
    |=> w_r == $past(rd_data_r) && !mem_wr_r.en)
    else $error("file copy d=0 not to accumulator");
  a_fcopy_flags: assert property ( // RL16
    q_r == mli_pkg::Q_WRITE && exec_first && is_fcopy
    |=> status_r.zero == ($past(rd_data_r) == 8'h00) &&
        status_r.neg == $past(rd_data_r[7]))
    else $error("file copy flags wrong");
  a_copy_noread: assert property ( // RL7
    seq_r == mli_pkg::SEQ_COPY2 |-> !mem_rd_r.en)
    else $error("dummy read in copy second cycle");
  a_copy_dest: assert property ( // RL8
    q_r == mli_pkg::Q_WRITE && seq_r == mli_pkg::SEQ_COPY2 && second_ok &&
    ir_r[11:0] != mli_pkg::ACC_ADDR
    |=> mem_wr_r.en && mem_wr_r.addr == $past(ir_r[11:0]))
    else $error("copy destination not written");
  a_ptr_two: assert property ( // RL1
    q_r == mli_pkg::Q_WRITE && exec_first && is_ptr_lit &&
    ir_r[5:4] != mli_pkg::PTR_INVALID
    |=> seq_r == mli_pkg::SEQ_PTR2 ##4 seq_r == mli_pkg::SEQ_FIRST)
    else $error("pointer load not two cycles");
  a_bank_addr: assert property ( // RL5
    q_r == mli_pkg::Q_READ && exec_first && is_fcopy && ir_r[8]
    |=> mem_rd_r.en && mem_rd_r.addr == {$past(bsr_r[3:0]),
                                         $past(ir_r[7:0])})
    else $error("banked address wrong");
  a_access_addr: assert property ( // RL4
    q_r == mli_pkg::Q_READ && exec_first && is_fcopy && !ir_r[8] &&
    !f_indexed
    |=> mem_rd_r.addr[11:8] == ($past(ir_r[7:0]) < 8'h60 ? 4'h0 : 4'hF))
    else $error("access bank address wrong");

endmodule // mli_exec_top

//--- mli_pkg.sv
// shared constants and types for the move and load instruction executor
package mli_pkg;

  // four-phase instruction cycle, one phase per clock
  localparam logic [1:0] Q_DECODE  = 2'h0;
  localparam logic [1:0] Q_READ    = 2'h1;
  localparam logic [1:0] Q_PROCESS = 2'h2;
  localparam logic [1:0] Q_WRITE   = 2'h3;

  // opcode patterns of the first word
  localparam logic [5:0] OP_FILE_COPY   = 6'h14;  // 0101 00da
  localparam logic [6:0] OP_ACC_STORE   = 7'h37;  // 0110 111a
  localparam logic [7:0] OP_ACC_LIT     = 8'h0E;  // 0000 1110
  localparam logic [7:0] OP_BANK_LIT    = 8'h01;  // 0000 0001
  localparam logic [3:0] OP_COPY_SRC    = 4'hC;   // 1100 fs
  localparam logic [9:0] OP_PTR_LIT     = 10'h3B8; // 1110 1110 00ff
  // second-word patterns
  localparam logic [3:0] OP_SECOND      = 4'hF;   // 1111 fd
  localparam logic [7:0] OP_PTR_SECOND  = 8'hF0;  // 1111 0000 kkkk kkkk

  // data space layout
  localparam logic [11:0] ACC_ADDR       = 12'hFE8; // accumulator location
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;   // low/high access halves
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [7:0]  INDEX_LIMIT    = 8'h5F;   // indexed when f <= 95
  localparam logic [1:0]  PTR_INVALID    = 2'h3;

  // reset values
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [7:0]  BANK_RST = 8'h00;
  localparam logic [11:0] PTR_RST  = 12'h000;
  localparam logic [7:0]  DATA_RST = 8'h00;

  // sequencer of two-word instructions
  typedef enum logic [1:0] {
    SEQ_FIRST = 2'b00,
    SEQ_PTR2  = 2'b01,
    SEQ_COPY2 = 2'b10
  } mli_seq_t;

  // data memory read request
  typedef struct packed {
    logic        en;
    logic [11:0] addr;
  } mli_mem_rd_t;

  // data memory write request
  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } mli_mem_wr_t;

  // status flags touched by this group
  typedef struct packed {
    logic neg;
    logic zero;
  } mli_status_t;

endpackage

//--- mli_addr_res.sv
// file operand to 12-bit data address resolver
`timescale 1ns/10ps
module mli_addr_res (
  input  wire logic [7:0]  file_i,
  input  wire logic        access_sel_i,
  input  wire logic [3:0]  bank_i,
  input  wire logic        ext_en_i,
  input  wire logic [11:0] index_base_i,
  output logic [11:0]      addr_o,
  output logic             indexed_o
);

  // indexed literal offset takes over low access half
  // RL6: indexed offset mode
  assign indexed_o = ext_en_i && !access_sel_i &&
                     (file_i <= mli_pkg::INDEX_LIMIT);

  // pick the address source
  always_comb begin
    if (indexed_o) begin
      addr_o = index_base_i + {4'h0, file_i};
    end else if (access_sel_i) begin
      // RL5: bank from selector
      addr_o = {bank_i, file_i};
    end else if (file_i < mli_pkg::ACCESS_SPLIT) begin
      // RL4: fixed access bank
      addr_o = {mli_pkg::ACCESS_LO_BANK, file_i};
    end else begin
      // RL3: 8-bit in-bank offset
      addr_o = {mli_pkg::ACCESS_HI_BANK, file_i};
    end
  end

endmodule // mli_addr_res

//--- mli_exec_top_bench.sv
// self-checking bench for the move and load instruction executor
`timescale 1ns/10ps
module mli_exec_top_bench;
  logic                 clk_sys_i;
  logic                 rst_i;
  logic [15:0]          instr_i;
  logic                 instr_valid_i;
  logic                 ext_set_en_i;
  logic [7:0]           mem_rd_data_i;
  mli_pkg::mli_mem_rd_t mem_rd_o;
  mli_pkg::mli_mem_wr_t mem_wr_o;
  logic [7:0]           acc_o;
  logic [7:0]           bank_selector_reg_o;
  logic [2:0][11:0]     indirect_pointer_o;
  mli_pkg::mli_status_t status_o;
  logic [1:0]           q_phase_o;
  logic                 instr_other_o;
  logic                 instr_bad_o;
  logic [7:0]           mem [4096];
  logic [11:0]          rd_addr;
  int                   rd_cnt;
  int                   bad_count;
  int                   n_compared;

  mli_exec_top DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .ext_set_en_i(ext_set_en_i),
    .mem_rd_data_i(mem_rd_data_i), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .acc_o(acc_o),
    .bank_selector_reg_o(bank_selector_reg_o),
    .indirect_pointer_o(indirect_pointer_o), .status_o(status_o),
    .q_phase_o(q_phase_o), .instr_other_o(instr_other_o),
    .instr_bad_o(instr_bad_o)
  );

  // 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // memory answers only while read is requested, else inverted junk
  assign mem_rd_data_i = mem_rd_o.en ? mem[mem_rd_o.addr]
                                     : ~mem[mem_rd_o.addr];

  // data memory model and read monitor
  always @(posedge clk_sys_i) begin
    if (mem_wr_o.en === 1'b1) begin
      mem[mem_wr_o.addr] <= mem_wr_o.data;
    end
    if (mem_rd_o.en === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_addr <= mem_rd_o.addr;
    end
  end

  // preset contents of every data location
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one instruction cycle of four phases, outputs settled at return
  task automatic cyc(input logic [15:0] w, input logic v = 1'b1);
    instr_i <= w;
    instr_valid_i <= v;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk(q_phase_o, 16'h0000);
  endtask

  // file copy with expected resolved address
  task automatic fc(input logic d, input logic a, input logic [7:0] f,
                    input logic [11:0] ea);
    logic [7:0] v;
    v = pat(ea);
    cyc({mli_pkg::OP_FILE_COPY, d, a, f});
    chk(rd_addr, ea);
    chk(status_o, {v[7], v == 8'h00});
    chk(mem_wr_o.en, d);
    if (d) begin
      chk(mem_wr_o.addr, ea);
      chk(mem_wr_o.data, v);
    end else begin
      chk(acc_o, v);
    end
  endtask

  // register to register copy, expected moved value v
  task automatic rc(input logic [11:0] s, input logic [11:0] dd,
                    input logic [7:0] v);
    int n;
    cyc({mli_pkg::OP_COPY_SRC, s});
    if (s != mli_pkg::ACC_ADDR) begin
      chk(rd_addr, s);
    end
    n = rd_cnt;
    cyc({mli_pkg::OP_SECOND, dd});
    chk(rd_cnt, n);
    chk(mem_wr_o.en, dd != mli_pkg::ACC_ADDR);
    if (dd == mli_pkg::ACC_ADDR) begin
      chk(acc_o, v);
    end else begin
      chk(mem_wr_o.addr, dd);
      chk(mem_wr_o.data, v);
    end
  endtask

  task automatic t_literal;
    cyc(16'h0E5A);
    chk(acc_o, 8'h5A);
    chk(status_o, 2'h0);
    cyc(16'h0F33);
    chk(instr_other_o, 1'b1);
    chk(acc_o, 8'h5A);
  endtask

  task automatic t_bank;
    cyc(16'h01FF);
    chk(bank_selector_reg_o, 8'h0F);
    cyc(16'h0102);
    chk(bank_selector_reg_o, 8'h02);
  endtask

  task automatic t_filecopy;
    fc(1'b0, 1'b1, 8'h20, 12'h220);
    fc(1'b1, 1'b1, 8'hFF, 12'h2FF);
    fc(1'b0, 1'b0, 8'h80, 12'hF80);
    fc(1'b1, 1'b0, 8'h10, 12'h010);
    fc(1'b0, 1'b0, 8'h00, 12'h000);
  endtask

  task automatic t_pointer;
    cyc(16'hEE23);
    chk(indirect_pointer_o[2][11:8], 4'h3);
    cyc(16'hF0AB);
    chk(indirect_pointer_o[2], 12'h3AB);
    cyc(16'hEE0F);
    cyc(16'hF0FF);
    chk(indirect_pointer_o[0], 12'hFFF);
    chk(indirect_pointer_o[1], 12'h000);
    ext_set_en_i <= 1'b1;
    fc(1'b0, 1'b0, 8'h05, 12'h3B0);
    fc(1'b0, 1'b0, 8'h5F, 12'h40A);
    fc(1'b0, 1'b0, 8'h60, 12'hF60);
    fc(1'b0, 1'b1, 8'h05, 12'h205);
    ext_set_en_i <= 1'b0;
  endtask

  task automatic t_store;
    cyc(16'h0E80);
    chk(status_o, 2'h0);
    cyc(16'h6E10);
    chk(mem_wr_o.en, 1'b1);
    chk(mem_wr_o.addr, 12'h010);
    chk(mem_wr_o.data, 8'h80);
    chk(status_o, 2'h0);
  endtask

  task automatic t_regcopy;
    rc(12'h123, 12'h456, pat(12'h123));
    rc(12'hFFF, 12'h000, pat(12'hFFF));
    rc(mli_pkg::ACC_ADDR, 12'h011, 8'h80);
    rc(12'h123, mli_pkg::ACC_ADDR, pat(12'h123));
  endtask

  task automatic t_refuse;
    cyc(16'h0E11, 1'b0);
    chk(acc_o, 8'h32);
    cyc(16'h0000);
    chk(instr_other_o, 1'b1);
    cyc(16'hEE3F);
    chk(instr_bad_o, 1'b1);
    cyc(16'hF055);
    chk(indirect_pointer_o[0], 12'hFFF);
    chk(indirect_pointer_o[2], 12'h3AB);
    cyc(16'hC123);
    cyc(16'h0E11);
    chk(mem_wr_o.en, 1'b0);
    chk(acc_o, 8'h32);
    chk(instr_bad_o, 1'b1);
  endtask

  // hang guard
  initial begin
    #200000;
    bad_count++;
    stop_test;
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    ext_set_en_i = 1'b0;
    rd_cnt = 0;
    rd_addr = 12'h000;
    bad_count = 0;
    n_compared = 0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = pat(i[11:0]);
    end
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_literal;
    t_bank;
    t_filecopy;
    t_pointer;
    t_store;
    t_regcopy;
    t_refuse;
    stop_test;
  end
endmodule // mli_exec_top_bench
